// ---- core/pkt_header_regs.svh ----
// Constants for the packet header framer
`ifndef PKT_HEADER_REGS_SVH
`define PKT_HEADER_REGS_SVH
`define SYNC_WORD 16'heb25
`define HDR_WORDS 4'd12
`define LAST_WORD 4'd11
`define VER_MIN 8'h01
`define VER_MAX 8'h05
`define SETUP_TYPE 8'h01
`define TYPE_MAX 8'h72
`define CHAN_COUNT 16
`define CHAN_BITS 4
`define FLAG_SEC 7
`define FLAG_TSRC 6
`define FLAG_SYNC 5
`define FLAG_OVF 4
`define CLK_MHZ 20
`define RTC_MHZ 10
`define RTC_DIV (`CLK_MHZ / `RTC_MHZ)
`endif

// ---- core/pkt_header_pkg.sv ----
// Types for the packet header framer
package pkt_header_pkg;
   typedef enum logic [1:0] {IDLE, EMIT, DONE} phase_t;
endpackage

// ---- core/pkt_header_framer.sv ----
// Packet header framer: builds the 24-byte header as twelve 16-bit words
`timescale 1ns/10ps
`default_nettype none
`include "pkt_header_regs.svh"
module pkt_header_framer
   import pkt_header_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] mux_bits_i,
   input wire logic [15:0] mux_source_i,
   input wire logic start_i,
   output logic start_ready_o,
   input wire logic [15:0] source_channel_identifier_i,
   input wire logic [31:0] packet_length_i,
   input wire logic [31:0] data_length_i,
   input wire logic [7:0] version_i,
   input wire logic [7:0] data_type_i,
   input wire logic sec_hdr_i,
   input wire logic sec_time_src_i,
   input wire logic sync_err_i,
   input wire logic overflow_i,
   input wire logic [1:0] time_fmt_i,
   input wire logic [1:0] cksum_size_i,
   input wire logic body_first_i,
   output logic [15:0] word_o,
   output logic word_valid_o,
   output logic word_last_o,
   input wire logic word_ready_i,
   output logic [47:0] rtc_o,
   output logic reject_o
);
   typedef struct packed {
      logic [1:0] rst_sync;
      logic rtc_div;
      logic [47:0] rtc;
      logic [47:0] stamp;
      phase_t phase;
      logic [3:0] idx;
      logic [15:0] sum;
      logic [15:0] chan;
      logic [31:0] plen;
      logic [31:0] dlen;
      logic [7:0] ver;
      logic [7:0] seq;
      logic [7:0] flags;
      logic [7:0] dtype;
      logic [1:0] cnt;
      logic [1:0][15:0] buf_data;
      logic [1:0] buf_last;
      logic buf_wr;
      logic buf_rd;
      logic reject;
   } state_t;

   state_t state_reg;
   state_t state_next;
   logic [7:0] seq_reg [`CHAN_COUNT];
   logic [`CHAN_BITS-1:0] chan_slot;
   logic [15:0] chan_id;
   logic [15:0] low_mask;
   logic [15:0] cur_word;
   logic [7:0] flags_w;
   logic ok;
   logic push;
   logic pop;
   logic rst_n;

   assign rst_n = state_reg.rst_sync[1];

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic [1:0] rsync;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rsync <= 2'h0;
      end else begin
         rsync <= {rsync[0], 1'b1};
      end
   end

   // ------------------------------------------------------------
   // Header field assembly
   // ------------------------------------------------------------
   // Multiplexer bits on top, source id in the remaining low bits
   assign low_mask = (mux_bits_i == 4'h0) ? 16'hffff : (16'hffff >> mux_bits_i);
   assign chan_id = ((mux_source_i << (5'd16 - {1'b0, mux_bits_i})) & ~low_mask)
      | (source_channel_identifier_i & low_mask);
   assign chan_slot = chan_id[`CHAN_BITS-1:0];
   // Time source bit forced low without a secondary header
   assign flags_w = {sec_hdr_i, sec_hdr_i & sec_time_src_i, sync_err_i, overflow_i,
      time_fmt_i, cksum_size_i};
   // Invalid requests are refused rather than emitted with bad fields
   assign ok = (version_i >= `VER_MIN) && (version_i <= `VER_MAX)
      && (packet_length_i[1:0] == 2'h0)
      && (data_length_i <= packet_length_i)
      && !time_fmt_i[1]
      && ((data_type_i == `SETUP_TYPE) == (chan_id == 16'h0000) || data_type_i == 8'h00)
      && (data_type_i <= `TYPE_MAX);
   assign start_ready_o = (state_reg.phase == IDLE);

   always_comb begin
      case (state_reg.idx)
         4'd0: cur_word = `SYNC_WORD;
         4'd1: cur_word = state_reg.chan;
         4'd2: cur_word = state_reg.plen[15:0];
         4'd3: cur_word = state_reg.plen[31:16];
         4'd4: cur_word = state_reg.dlen[15:0];
         4'd5: cur_word = state_reg.dlen[31:16];
         4'd6: cur_word = {state_reg.seq, state_reg.ver};
         4'd7: cur_word = {state_reg.dtype, state_reg.flags};
         4'd8: cur_word = state_reg.stamp[15:0];
         4'd9: cur_word = state_reg.stamp[31:16];
         4'd10: cur_word = state_reg.stamp[47:32];
         4'd11: cur_word = state_reg.sum;
         default: cur_word = 16'h0000;
      endcase
   end

   // ------------------------------------------------------------
   // Two-entry output buffer
   // ------------------------------------------------------------
   assign push = (state_reg.phase == EMIT) && (state_reg.cnt != 2'd2);
   assign pop = word_valid_o && word_ready_i;
   assign word_valid_o = (state_reg.cnt != 2'd0);
   assign word_o = state_reg.buf_data[state_reg.buf_rd];
   assign word_last_o = word_valid_o && state_reg.buf_last[state_reg.buf_rd];
   assign rtc_o = state_reg.rtc;
   assign reject_o = state_reg.reject;

   always_comb begin
      state_next = state_reg;
      state_next.rst_sync = rsync;
      state_next.reject = 1'b0;
      // Free-running divider; counts across packets and never reloads
      state_next.rtc_div = ~state_reg.rtc_div;
      if (state_reg.rtc_div) begin
         state_next.rtc = state_reg.rtc + 48'h1;
      end
      if (body_first_i) begin
         state_next.stamp = state_reg.rtc;
      end
      case (state_reg.phase)
         IDLE: begin
            if (start_i) begin
               if (ok) begin
                  state_next.phase = EMIT;
                  state_next.idx = 4'd0;
                  state_next.chan = chan_id;
                  state_next.plen = packet_length_i;
                  state_next.dlen = data_length_i;
                  state_next.ver = version_i;
                  state_next.seq = seq_reg[chan_slot];
                  state_next.flags = flags_w;
                  state_next.dtype = data_type_i;
               end else begin
                  state_next.reject = 1'b1;
               end
            end
         end
         EMIT: begin
            if (push) begin
               if (state_reg.idx == 4'd0) begin
                  state_next.sum = cur_word;
               end else if (state_reg.idx != `LAST_WORD) begin
                  state_next.sum = state_reg.sum + cur_word;
               end
               state_next.idx = state_reg.idx + 4'd1;
               if (state_reg.idx == `LAST_WORD) begin
                  state_next.phase = DONE;
               end
            end
         end
         DONE: begin
            if (state_reg.cnt == 2'd0) begin
               state_next.phase = IDLE;
            end
         end
         default: state_next.phase = IDLE;
      endcase
      if (push) begin
         state_next.buf_data[state_reg.buf_wr] = cur_word;
         state_next.buf_last[state_reg.buf_wr] = (state_reg.idx == `LAST_WORD);
         state_next.buf_wr = ~state_reg.buf_wr;
      end
      if (pop) begin
         state_next.buf_rd = ~state_reg.buf_rd;
      end
      state_next.cnt = state_reg.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= '0;
      end else if (!rst_n) begin
         state_reg <= '0;
         state_reg.rst_sync <= rsync;
      end else begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------
   // Per-channel sequence counters
   // ------------------------------------------------------------
   // Only the low id bits pick a slot; wider systems alias channels
   genvar g;
   generate
      for (g = 0; g < `CHAN_COUNT; g++) begin : g_seq
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               seq_reg[g] <= 8'h00;
            end else if (rst_n && state_reg.phase == IDLE && start_i && ok && chan_slot == g) begin
               seq_reg[g] <= seq_reg[g] + 8'h01;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Field checks
   // ------------------------------------------------------------
   AST_SYNC_FIRST: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state_reg.phase == EMIT && state_reg.idx == 4'd0 && push) |=> state_reg.buf_data[$past(state_reg.buf_wr)] == `SYNC_WORD)
      else $error("sync word wrong");

   AST_VER_RANGE: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_reg.phase == EMIT |-> state_reg.ver >= `VER_MIN && state_reg.ver <= `VER_MAX)
      else $error("bad version");

   AST_LEN_ALIGN: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_reg.phase == EMIT |-> state_reg.plen[1:0] == 2'h0)
      else $error("length unaligned");

   AST_DLEN_FIT: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_reg.phase == EMIT |-> state_reg.dlen <= state_reg.plen)
      else $error("data length beyond packet");

   AST_TSRC: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_reg.flags[`FLAG_TSRC] |-> state_reg.flags[`FLAG_SEC])
      else $error("time source without sec");

   AST_FMT: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_reg.phase == EMIT |-> !state_reg.flags[3])
      else $error("reserved time format");

   AST_TYPE_MAX: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_reg.phase == EMIT |-> state_reg.dtype <= `TYPE_MAX)
      else $error("unassigned data type");

   AST_CH0_TYPE: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state_reg.phase == EMIT && state_reg.chan == 16'h0000) |-> state_reg.dtype <= `SETUP_TYPE)
      else $error("channel zero type");

   AST_SETUP_CH0: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state_reg.phase == EMIT && state_reg.dtype == `SETUP_TYPE) |-> state_reg.chan == 16'h0000)
      else $error("setup record off channel zero");

   AST_FLAG_SEC: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state_reg.phase == IDLE && start_i && ok) |=> state_reg.flags[`FLAG_SEC] == $past(sec_hdr_i))
      else $error("secondary header flag");

   AST_FLAG_ERR: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state_reg.phase == IDLE && start_i && ok) |=> state_reg.flags[`FLAG_SYNC] == $past(sync_err_i)
      && state_reg.flags[`FLAG_OVF] == $past(overflow_i))
      else $error("error flags");

   AST_FLAG_CKS: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state_reg.phase == IDLE && start_i && ok) |=> state_reg.flags[1:0] == $past(cksum_size_i))
      else $error("checksum size flags");

   // ------------------------------------------------------------
   // Counter checks
   // ------------------------------------------------------------
   AST_SEQ_INC: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state_reg.phase == IDLE && start_i && ok) |=> state_reg.seq == $past(seq_reg[chan_slot])
      && seq_reg[$past(chan_slot)] == $past(seq_reg[chan_slot]) + 8'h01)
      else $error("sequence step");

   AST_SEQ_WRAP: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state_reg.phase == IDLE && start_i && ok && seq_reg[chan_slot] == 8'hff) |=> seq_reg[$past(chan_slot)] == 8'h00)
      else $error("sequence wrap");

   AST_RTC_RUN: assert property (@(posedge clk_i) disable iff (!rst_n)
      ##1 state_reg.rtc == $past(state_reg.rtc, 2) + 48'h1 || $past(rst_n, 2) == 1'b0)
      else $error("time counter stalled");

   AST_RTC_STEP: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_reg.rtc_div |=> state_reg.rtc == $past(state_reg.rtc) + 48'h1)
      else $error("time counter step");

   AST_RTC_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
      !state_reg.rtc_div |=> state_reg.rtc == $past(state_reg.rtc))
      else $error("time counter too fast");

   AST_STAMP: assert property (@(posedge clk_i) disable iff (!rst_n)
      body_first_i |=> state_reg.stamp == $past(state_reg.rtc))
      else $error("stamp not latched");

   AST_SUM_START: assert property (@(posedge clk_i) disable iff (!rst_n)
      (push && state_reg.idx == 4'd0) |=> state_reg.sum == `SYNC_WORD)
      else $error("checksum start");

   AST_SUM_STEP: assert property (@(posedge clk_i) disable iff (!rst_n)
      (push && state_reg.idx != 4'd0 && state_reg.idx != `LAST_WORD)
      |=> state_reg.sum == $past(state_reg.sum) + $past(cur_word))
      else $error("checksum step");

   AST_LAST_SUM: assert property (@(posedge clk_i) disable iff (!rst_n)
      word_last_o |-> word_o == state_reg.sum)
      else $error("last word not checksum");

   // ------------------------------------------------------------
   // Flow checks
   // ------------------------------------------------------------
   AST_HDR_LEN: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state_reg.phase == IDLE && start_i && ok) |=> state_reg.phase == EMIT [*1] ##[1:40] state_reg.phase == DONE)
      else $error("header not finished");

   AST_ACCEPT: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state_reg.phase == IDLE && start_i && ok) |=> !reject_o && !start_ready_o)
      else $error("accepted start not taken");

   AST_REFUSE: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state_reg.phase == IDLE && start_i && !ok) |=> reject_o && start_ready_o)
      else $error("refused start not flagged");

   AST_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
      (word_valid_o && !word_ready_i) |=> word_valid_o && $stable(word_o) && $stable(word_last_o))
      else $error("word dropped under stall");

   AST_BUF_DEPTH: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_reg.cnt != 2'd3)
      else $error("buffer overfilled");

   AST_IDLE_EMPTY: assert property (@(posedge clk_i) disable iff (!rst_n)
      start_ready_o |-> !word_valid_o)
      else $error("ready with words pending");

   AST_IDX_RANGE: assert property (@(posedge clk_i) disable iff (!rst_n)
      state_reg.phase == EMIT |-> state_reg.idx <= `LAST_WORD)
      else $error("word index out of range");
endmodule
`default_nettype wire

// ---- tb/word_sink.sv ----
// Consumer model that takes header words off the framer
`timescale 1ns/10ps
`default_nettype none
module word_sink (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic stall_i,
   input wire logic [15:0] word_i,
   input wire logic valid_i,
   input wire logic last_i,
   output logic ready_o
);
   logic [15:0] q[$];
   logic lq[$];
   // Ready moves off the sampling edge so a stall never races the push
   always @(negedge clk_i) ready_o <= rst_n_i && !stall_i;
   always @(posedge clk_i) begin
      if (valid_i && ready_o) begin
         q.push_back(word_i);
         lq.push_back(last_i);
      end
   end
endmodule
`default_nettype wire

// ---- tb/recorder_packet_header_framer_test.sv ----
// Testbench for the packet header framer
`timescale 1ns/10ps
`default_nettype none
module recorder_packet_header_framer_test;
   import pkt_header_pkg::*;
   logic clk_i = 0, rst_n_i = 0, start = 0, sec = 0, tsrc = 0, serr = 0, ovf = 0, bf = 0, stall = 0;
   logic [3:0] mb = 0;
   logic [15:0] src = 0, id = 0, word;
   logic [31:0] plen = 0, dlen = 0;
   logic [7:0] ver = 0, typ = 0;
   logic [1:0] fmt = 0, ck = 0;
   logic rdy, vld, last, ready, rej;
   logic [47:0] rtc, a;
   logic [7:0] seq[16];
   int fails = 0, n_tests = 0, cyc = 0;
   pkt_header_framer u_pkt_header_framer (.clk_i(clk_i), .rst_n_i(rst_n_i), .mux_bits_i(mb), .mux_source_i(src),
      .start_i(start), .start_ready_o(rdy), .source_channel_identifier_i(id), .packet_length_i(plen),
      .data_length_i(dlen), .version_i(ver), .data_type_i(typ), .sec_hdr_i(sec), .sec_time_src_i(tsrc),
      .sync_err_i(serr), .overflow_i(ovf), .time_fmt_i(fmt), .cksum_size_i(ck), .body_first_i(bf),
      .word_o(word), .word_valid_o(vld), .word_last_o(last), .word_ready_i(ready), .rtc_o(rtc), .reject_o(rej));
   word_sink u_word_sink (.clk_i(clk_i), .rst_n_i(rst_n_i), .stall_i(stall), .word_i(word), .valid_i(vld),
      .last_i(last), .ready_o(ready));
   initial forever #25 clk_i = ~clk_i;
   // ----------------------------------------
   // Checking helpers
   // ----------------------------------------
   task automatic chk(input string what, input logic [47:0] e, input logic [47:0] g);
      n_tests++;
      if (e !== g) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic randf(input logic [3:0] nib);
      mb = 4'($urandom % 5);
      src = 16'($urandom);
      id = {12'($urandom), nib};
      plen = {18'h0, 12'($urandom), 2'b00};
      dlen = $urandom % (plen + 1);
      ver = 8'(1 + $urandom % 5);
      typ = 8'(2 + $urandom % 8'h71);
      sec = 1'($urandom);
      tsrc = sec & 1'($urandom);
      {serr, ovf} = 2'($urandom);
      fmt = 2'($urandom % 2);
      ck = 2'($urandom);
   endtask
   // Builds expected words and compares a whole header or a refusal
   task automatic send(input logic exp_rej);
      logic [15:0] e[12];
      logic [15:0] ch, sum;
      logic [47:0] st;
      logic seen;
      int k;
      k = 0;
      while (rdy !== 1'b1 && k < 100) begin
         @(negedge clk_i);
         k++;
      end
      chk("ready", 1, rdy);
      bf = 1;
      st = rtc;
      @(negedge clk_i);
      bf = 0;
      start = 1;
      @(negedge clk_i);
      start = 0;
      seen = 0;
      repeat (3) begin
         seen |= (rej === 1'b1);
         @(negedge clk_i);
      end
      chk("reject", exp_rej, seen);
      if (exp_rej) begin
         chk("no words", 0, u_word_sink.q.size());
         return;
      end
      ch = mb == 0 ? id : ((src << (16 - mb)) | (id & (16'hffff >> mb)));
      e = '{16'heb25, ch, plen[15:0], plen[31:16], dlen[15:0], dlen[31:16], {seq[ch[3:0]], ver},
         {typ, sec, tsrc, serr, ovf, fmt, ck}, st[15:0], st[31:16], st[47:32], 16'h0};
      sum = 0;
      for (int i = 0; i < 11; i++) sum += e[i];
      e[11] = sum;
      k = 0;
      while (u_word_sink.q.size() < 12 && k < 400) begin
         @(negedge clk_i);
         k++;
      end
      chk("count", 12, u_word_sink.q.size());
      for (int i = 0; i < 12 && u_word_sink.q.size() > 0; i++) begin
         chk($sformatf("word%0d", i), e[i], u_word_sink.q.pop_front());
         chk("last", i == 11, u_word_sink.lq.pop_front());
      end
      seq[ch[3:0]]++;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 40000) begin
         fails++;
         report_and_stop();
      end
   end
   always @(negedge clk_i) stall <= 1'($urandom % 4 == 0);
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(38485));
      foreach (seq[i]) seq[i] = 8'h00;
      repeat (4) @(negedge clk_i);
      rst_n_i = 1;
      repeat (4) @(negedge clk_i);
      a = rtc;
      repeat (20) @(negedge clk_i);
      chk("rtc rate", a + 10, rtc);
      for (int i = 0; i < 300; i++) begin
         randf(i < 280 ? 4'h3 : 4'(1 + $urandom % 15));
         send(0);
      end
      for (int i = 0; i < 2; i++) begin
         randf(4'h0);
         mb = 0;
         id = 0;
         typ = 8'(i);
         send(0);
      end
      for (int r = 0; r < 9; r++) begin
         randf(4'h5);
         mb = 0;
         case (r)
            0: ver = 8'h00;
            1: ver = 8'h06;
            2: plen[0] = 1;
            3: dlen = plen + 4;
            4: fmt = 2'b10;
            5: fmt = 2'b11;
            6: typ = 8'h01;
            7: typ = 8'h73;
            default: begin
               id = 0;
               typ = 8'h02;
            end
         endcase
         send(1);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
